// ===== shared/spi_status_readout_defines.svh
// Constants of the serial status readout block
`ifndef SPI_STATUS_READOUT_DEFINES_SVH
`define SPI_STATUS_READOUT_DEFINES_SVH
// Frame layout: mode field, select field, data field, MSB first
`define FRAME_BITS 16
`define HDR_BITS 6
`define CNT_W 5
`define DATA_W 10
`define MODE_MSB 15
`define MODE_LSB 13
`define SEL_MSB 12
`define SEL_LSB 10
// Limp word layout inside the data field
`define LIMP_ON_BIT 5
`define RR_MSB 4
`define RR_LSB 3
`define LH_MSB 2
`define LH_LSB 0
// Wake flags that mirror a live condition and survive a read
`define WAKE_LIVE_MASK 10'h300
// Register byte offsets
`define ADDR_W 12
`define OFS_MODE 12'h000
`define OFS_CONFIG 12'h004
`define OFS_WAKE 12'h008
`define OFS_LIMP 12'h00C
`define OFS_STATUS 12'h010
// Mode register fields
`define MR_BY_MCU_BIT 3
`define MR_HW13_BIT 4
// Reset values
`define RST_CONFIG 10'h000
`define RST_LIMP_CODE 3'h0
`define RST_RR 2'h0
`endif

// ===== shared/spi_status_readout_pkg.sv
// Types of the serial status readout block
package spi_status_readout_pkg;
  // Chip mode codes, also the frame mode field
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_SLEEP = 3'h1,
    MODE_RESTART = 3'h2,
    MODE_FAILSAFE = 3'h3,
    MODE_INIT = 3'h4,
    MODE_READ_ONLY = 3'h7
  } chip_mode_t;
  // Configuration select codes
  typedef enum logic [2:0] {
    SEL_CONFIG = 3'h0,
    SEL_WAKE = 3'h1,
    SEL_STATUS = 3'h2,
    SEL_LIMP = 3'h7
  } cfg_sel_t;
  // Frame sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_APPLY = 3'b100
  } frame_state_t;
endpackage

// ===== hdl/spi_status_readout.sv
// Serial slave response selection with APB register access
// Overview of operation
// - Non read-only frames return the word selected by the previous frame
// - First normal-mode frame reports prior mode with sleep/fail-safe/init word
// - Prior restart on failure, config 1/3: report restart, limp word
// - Prior restart commanded by controller: report restart, config word
// - First-frame automatic readout leaves all flags untouched
// - Read-only code in mode field marks a read-only request
// - Read-only clears selected interrupt flags except live-state ones
// - Read-only writes no configuration and keeps the chip mode
// - Read-only frame counts as watchdog service
// - Read-only frame returns its own selected word in the same frame
// - Reset reason cleared by read-only readout of the limp word or arrival in normal from sleep/fail-safe
// - Limp failure code returns to zero when a frame switches limp output off
//
// Register access over APB and the register offsets were decided locally.
`include "spi_status_readout_defines.svh"
module spi_status_readout
  import spi_status_readout_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Serial link pins
  input wire logic SPI_CLK_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_SDI_I,
  output logic SPI_SDO_O,
  output logic SPI_SDO_OE_O,
  // Chip side outputs
  output logic WD_SERVICE_O,
  output logic LIMP_ON_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] pin_raw;
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  assign pin_raw = {SPI_CLK_I, SPI_CS_N_I, SPI_SDI_I};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      // Two flops per pin
      always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
          pin_meta_reg[gi] <= (gi == 1);
          pin_sync_reg[gi] <= (gi == 1);
        end else begin
          pin_meta_reg[gi] <= pin_raw[gi];
          pin_sync_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  logic sclk_s, cs_n_s, sdi_s;
  logic sclk_d_reg, cs_n_d_reg;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  assign {sclk_s, cs_n_s, sdi_s} = pin_sync_reg;

  // Edge detection on synchronised pins
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      sclk_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_d_reg & ~cs_n_s;
  assign cs_fall = ~cs_n_s & cs_n_d_reg;
  assign cs_rise = cs_n_s & ~cs_n_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  chip_mode_t chip_mode_reg, prior_mode_reg;
  logic by_mcu_reg, hw13_reg, first_pending_reg;
  logic [`DATA_W-1:0] config_reg, wake_reg;
  logic [2:0] limp_code_reg;
  logic [1:0] rr_reg;
  logic limp_on_reg;
  logic [7:0] frame_cnt_reg;
  cfg_sel_t prev_sel_reg;
  frame_state_t state_reg;
  logic [`CNT_W-1:0] bit_cnt_reg;
  logic [`FRAME_BITS-1:0] rx_reg, tx_reg, cmd_reg;
  logic [`FRAME_BITS-1:0] rx_next;
  logic [31:0] status_word;

  // Data field for a configuration select code
  function automatic logic [`DATA_W-1:0] word_select(input logic [2:0] sel);
    logic [`DATA_W-1:0] w;
    w = '0;
    unique case (sel)
      SEL_CONFIG: w = config_reg;
      SEL_WAKE: w = wake_reg;
      SEL_STATUS: w = status_word[`DATA_W-1:0];
      SEL_LIMP: w = {4'h0, limp_on_reg, rr_reg, limp_code_reg};
      default: w = '0;
    endcase
    return w;
  endfunction

  // Decoded command held after the frame
  chip_mode_t cmd_mode;
  logic [2:0] cmd_sel;
  logic [`DATA_W-1:0] cmd_data;
  logic cmd_ro, apply;
  assign cmd_mode = chip_mode_t'(cmd_reg[`MODE_MSB:`MODE_LSB]);
  assign cmd_sel = cmd_reg[`SEL_MSB:`SEL_LSB];
  assign cmd_data = cmd_reg[`DATA_W-1:0];
  assign cmd_ro = (cmd_mode == MODE_READ_ONLY);
  assign apply = (state_reg == ST_APPLY);
  assign rx_next = {rx_reg[`FRAME_BITS-2:0], sdi_s};

  ////////////////////////////////////////////////////////////////////////////
  // APB access decode
  logic apb_acc, apb_wr;
  assign apb_acc = PSEL_I & PENABLE_I & ~PREADY_O;
  // Writes land on the completing edge, while ready stands
  assign apb_wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;

  // Chip mode source: APB write or non read-only command
  chip_mode_t mode_next;
  logic mode_wr;
  always_comb begin
    mode_wr = 1'b0;
    mode_next = chip_mode_reg;
    if (apb_wr && PADDR_I == `OFS_MODE) begin
      mode_wr = 1'b1;
      mode_next = chip_mode_t'(PWDATA_I[2:0]);
    end else if (apply && !cmd_ro) begin
      mode_wr = 1'b1;
      mode_next = cmd_mode;
    end
  end

  logic enter_normal;
  assign enter_normal = mode_wr && mode_next == MODE_NORMAL &&
                        chip_mode_reg != MODE_NORMAL;

  // Chip mode, restart cause and strap
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      chip_mode_reg <= MODE_INIT;
      by_mcu_reg <= 1'b0;
      hw13_reg <= 1'b0;
    end else begin
      if (mode_wr) begin
        chip_mode_reg <= mode_next;
      end
      if (apb_wr && PADDR_I == `OFS_MODE) begin
        by_mcu_reg <= PWDATA_I[`MR_BY_MCU_BIT];
        hw13_reg <= PWDATA_I[`MR_HW13_BIT];
      end else if (apply && !cmd_ro && cmd_mode == MODE_RESTART) begin
        by_mcu_reg <= 1'b1;
      end
    end
  end

  // Track prior mode for first frame
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      prior_mode_reg <= MODE_INIT;
      first_pending_reg <= 1'b0;
    end else if (enter_normal) begin
      prior_mode_reg <= chip_mode_reg;
      first_pending_reg <= 1'b1;
    end else if (apply) begin
      first_pending_reg <= 1'b0;
    end
  end

  // Configuration word
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      config_reg <= `RST_CONFIG;
    end else if (apb_wr && PADDR_I == `OFS_CONFIG) begin
      config_reg <= PWDATA_I[`DATA_W-1:0];
    end else if (apply && !cmd_ro && cmd_sel == SEL_CONFIG) begin
      config_reg <= cmd_data;
    end
  end

  // Wake flags: events set, read-only clears, set wins
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      wake_reg <= '0;
    end else begin
      wake_reg <= (apb_wr && PADDR_I == `OFS_WAKE) ?
                  (wake_reg | PWDATA_I[`DATA_W-1:0]) : wake_reg;
      if (apply && cmd_ro && cmd_sel == SEL_WAKE) begin
        wake_reg <= (wake_reg & `WAKE_LIVE_MASK) |
                    ((apb_wr && PADDR_I == `OFS_WAKE) ?
                     PWDATA_I[`DATA_W-1:0] : '0);
      end
    end
  end

  // Limp output, failure code and reset reason
  logic limp_set, rr_clr;
  assign limp_set = apb_wr && PADDR_I == `OFS_LIMP;
  // Clear on read-only limp readout or arrival in normal from sleep/fail-safe
  assign rr_clr = (apply && cmd_ro && cmd_sel == SEL_LIMP) ||
                  (enter_normal && (chip_mode_reg == MODE_SLEEP ||
                                    chip_mode_reg == MODE_FAILSAFE));
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      limp_code_reg <= `RST_LIMP_CODE;
      rr_reg <= `RST_RR;
      limp_on_reg <= 1'b0;
    end else begin
      if (apply && !cmd_ro && cmd_sel == SEL_LIMP &&
          !cmd_data[`LIMP_ON_BIT]) begin
        limp_on_reg <= 1'b0;
        limp_code_reg <= 3'h0;
      end
      if (rr_clr) begin
        rr_reg <= 2'h0;
      end
      if (limp_set) begin
        limp_on_reg <= PWDATA_I[`LIMP_ON_BIT];
        limp_code_reg <= PWDATA_I[`LH_MSB:`LH_LSB];
        rr_reg <= PWDATA_I[`RR_MSB:`RR_LSB];
      end
    end
  end
  assign status_word = {14'h0, frame_cnt_reg, cmd_reg[`MODE_MSB:`MODE_LSB],
                        prev_sel_reg, prior_mode_reg, first_pending_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (cs_fall) begin
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (cs_rise) begin
            state_reg <= (bit_cnt_reg == `CNT_W'(`FRAME_BITS)) ?
                         ST_APPLY : ST_IDLE;
          end
        end
        ST_APPLY: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Receive shift and bit count
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      rx_reg <= '0;
      bit_cnt_reg <= '0;
      cmd_reg <= '0;
    end else if (cs_fall) begin
      bit_cnt_reg <= '0;
    end else if (state_reg == ST_SHIFT && sclk_rise) begin
      rx_reg <= rx_next;
      if (bit_cnt_reg != `CNT_W'(`FRAME_BITS)) begin
        bit_cnt_reg <= bit_cnt_reg + `CNT_W'(1);
      end
    end else if (state_reg == ST_SHIFT && cs_rise &&
                 bit_cnt_reg == `CNT_W'(`FRAME_BITS)) begin
      cmd_reg <= rx_reg;
    end
  end

  // Header and word chosen at frame start
  logic [`FRAME_BITS-1:0] start_word;
  always_comb begin
    start_word = {chip_mode_reg, prev_sel_reg, word_select(prev_sel_reg)};
    if (first_pending_reg) begin
      unique case (prior_mode_reg)
        MODE_SLEEP: start_word = {MODE_SLEEP, SEL_WAKE, wake_reg};
        MODE_FAILSAFE: start_word = {MODE_FAILSAFE, SEL_LIMP,
                                     word_select(SEL_LIMP)};
        MODE_RESTART: begin
          if (by_mcu_reg) begin
            start_word = {MODE_RESTART, SEL_CONFIG, config_reg};
          end else if (hw13_reg) begin
            start_word = {MODE_RESTART, SEL_LIMP, word_select(SEL_LIMP)};
          end else begin
            start_word = {MODE_RESTART, SEL_CONFIG, config_reg};
          end
        end
        default: start_word = {prior_mode_reg, SEL_CONFIG, config_reg};
      endcase
    end
  end

  // Transmit shift, output data and enable
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      tx_reg <= '0;
      SPI_SDO_O <= 1'b0;
      SPI_SDO_OE_O <= 1'b0;
    end else begin
      SPI_SDO_OE_O <= ~cs_n_s;
      if (cs_fall) begin
        // Reply lags request by one frame
        SPI_SDO_O <= start_word[`FRAME_BITS-1];
        tx_reg <= {start_word[`FRAME_BITS-2:0], 1'b0};
      end else if (state_reg == ST_SHIFT && sclk_rise &&
                   bit_cnt_reg == `CNT_W'(`HDR_BITS - 1) &&
                   rx_next[5:3] == MODE_READ_ONLY) begin
        tx_reg <= {word_select(rx_next[2:0]), 6'h0};
      end else if (state_reg == ST_SHIFT && sclk_fall) begin
        SPI_SDO_O <= tx_reg[`FRAME_BITS-1];
        tx_reg <= {tx_reg[`FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  // Previous select, frame count, watchdog service
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      prev_sel_reg <= SEL_CONFIG;
      frame_cnt_reg <= '0;
      WD_SERVICE_O <= 1'b0;
    end else begin
      WD_SERVICE_O <= apply;
      if (apply) begin
        prev_sel_reg <= cfg_sel_t'(cmd_sel);
        frame_cnt_reg <= frame_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      LIMP_ON_O <= 1'b0;
    end else begin
      LIMP_ON_O <= limp_on_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait state, registered data
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= '0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= apb_acc;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= '0;
      if (apb_acc) begin
        unique case (PADDR_I)
          `OFS_MODE: PRDATA_O <= {27'h0, hw13_reg, by_mcu_reg, chip_mode_reg};
          `OFS_CONFIG: PRDATA_O <= {22'h0, config_reg};
          `OFS_WAKE: PRDATA_O <= {22'h0, wake_reg};
          `OFS_LIMP: PRDATA_O <= {26'h0, limp_on_reg, rr_reg, limp_code_reg};
          `OFS_STATUS: PRDATA_O <= status_word;
          default: PSLVERR_O <= 1'b1;
        endcase
      end
    end
  end

endmodule // spi_status_readout

// ===== test/spi_status_readout_monitor.sv
// Port-level assertion checker for the serial status readout block
module spi_status_readout_monitor (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  // APB side
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [31:0] PRDATA_O,
  // Serial and chip side
  input wire logic SPI_CS_N_I,
  input wire logic SPI_SDO_OE_O,
  input wire logic WD_SERVICE_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  ////////////////////////////////////////////////////////////////////////////
  // APB answer timing
  property p_ack;
    PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O;
  endproperty
  a_ack: assert property (p_ack) else $error("APB access left unanswered");
  property p_pulse;
    PREADY_O |=> !PREADY_O;
  endproperty
  a_pulse: assert property (p_pulse) else $error("Ready held too long");
  property p_rdz;
    !PREADY_O |-> PRDATA_O == 32'h0;
  endproperty
  a_rdz: assert property (p_rdz) else $error("Read data outside ready");
  property p_err;
    PSLVERR_O |-> PREADY_O;
  endproperty
  a_err: assert property (p_err) else $error("Error without ready");
  ////////////////////////////////////////////////////////////////////////////
  // Serial output enable follows chip select
  property p_oe_on;
    $fell(SPI_CS_N_I) |-> ##[1:4] SPI_SDO_OE_O;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("Output not enabled");
  property p_oe_off;
    SPI_CS_N_I [*5] |-> !SPI_SDO_OE_O;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("Output enabled idle");
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog service pulse per finished frame
  property p_wd_pulse;
    WD_SERVICE_O |=> !WD_SERVICE_O;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse) else $error("Service too long");
  property p_wd_end;
    WD_SERVICE_O |-> SPI_CS_N_I && $past(SPI_CS_N_I, 3) && !SPI_SDO_OE_O;
  endproperty
  a_wd_end: assert property (p_wd_end) else $error("Service inside frame");
  // Main scenarios reached
  c_err: cover property (PREADY_O && PSLVERR_O);
  c_rd: cover property (PREADY_O && !PSLVERR_O);
  c_wd: cover property (WD_SERVICE_O);
endmodule // spi_status_readout_monitor

// ===== test/spi_host_model.sv
// Host controller model acting as serial master
module spi_host_model (
  // Serial pins toward the slave
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  // Slave answer
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  event done;
  logic [15:0] rx;
  // Idle levels: clock low, select pulled up, data pulled down
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  task frame(input logic [15:0] tx, input int nb);
    #13 cs_n_o = 1'b0;
    #250;
    // Fewer than 16 clocks makes a cut frame
    for (int i = 15; i >= 16 - nb; i--) begin
      sdi_o = tx[i];
      #80 sclk_o = 1'b1;
      // Sampled late in the high phase for margin
      #75 rx[i] = (sdo_oe_i === 1'b1) ? sdo_i : 1'bx;
      #5 sclk_o = 1'b0;
    end
    #170 sdi_o = 1'b0;
    cs_n_o = 1'b1;
    #10000;
    ->done;
  endtask
endmodule // spi_host_model

// ===== test/spi_status_readout_test.sv
// Self-checking bench for the serial status readout block
`include "spi_status_readout_defines.svh"
module spi_status_readout_test
  import spi_status_readout_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [32:0] v; logic [32:0] m;} note_t;
  note_t notes[$];
  logic clk, rst, psel, pen, pwr, pready, pslverr, sclk, chip_select_n, sdi, sdo, oe;
  logic wd, limp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0] cfg;
  int errors = 0, checked = 0, wd_n = 0, nfr = 0;
  spi_status_readout i_spi_status_readout (.CLK_SYS_I(clk), .SYS_RST_I(rst),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .SPI_CLK_I(sclk), .SPI_CS_N_I(chip_select_n),
    .SPI_SDI_I(sdi), .SPI_SDO_O(sdo), .SPI_SDO_OE_O(oe),
    .WD_SERVICE_O(wd), .LIMP_ON_O(limp));
  spi_host_model i_spi_host_model (.sclk_o(sclk), .cs_n_o(chip_select_n),
    .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(oe));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and queue helpers
  task chk(input string w, input logic [32:0] s, input logic [32:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", w, e, s);
    end
  endtask
  task wrap_up;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task pop_chk(input string w, input logic [32:0] s);
    note_t n;
    if (notes.size() != 0) n = notes.pop_front();
    else begin
      n.m = '1;
      n.v = ~s;
    end
    chk(w, s & n.m, n.v);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // APB master and frame driver, each noting its expectation
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    // Writes note only that no error answer is due
    if (w) notes.push_back('{33'h0, 33'h100000000});
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    notes.push_back('{e, m});
    apb(1'b0, a, 32'h0);
  endtask
  task fr(input logic [5:0] h, input logic [9:0] d, input logic ck,
          input logic [15:0] e);
    if (ck) notes.push_back('{{17'h0, e}, 33'h0FFFF});
    else notes.push_back('{33'h0, 33'h0});
    i_spi_host_model.frame({h, d}, 16);
    nfr++;
  endtask
  // Result watchers take the oldest note
  always @(posedge clk) if (pready === 1'b1) pop_chk("apb", {pslverr, prdata});
  always @(i_spi_host_model.done) pop_chk("frame", {17'h0, i_spi_host_model.rx});
  always @(posedge clk) if (wd === 1'b1) wd_n++;
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [4:0] mv[5];
    cfg_sel_t sv[5];
    logic [9:0] dv[5];
    {rst, psel, pen, pwr, paddr, pwdata} = '0;
    rst = 1'b1;
    void'($urandom(2));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    cfg = 10'($urandom);
    rd(`OFS_CONFIG, 33'(`RST_CONFIG), '1);
    rd(12'h014, 33'h100000000, '1);
    apb(1'b1, `OFS_CONFIG, {22'h0, cfg});
    apb(1'b1, `OFS_LIMP, 32'h25);
    apb(1'b1, `OFS_WAKE, 32'h3FF);
    chk("limp_on", 33'(limp), 33'h1);
    mv = '{5'h04, 5'h01, 5'h03, 5'h12, 5'h0A};
    sv = '{SEL_CONFIG, SEL_WAKE, SEL_LIMP, SEL_LIMP, SEL_CONFIG};
    dv = '{cfg, 10'h3FF, 10'h025, 10'h025, cfg};
    // first frame after each prior mode
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `OFS_MODE, {27'h0, mv[i]});
      fr({MODE_NORMAL, SEL_CONFIG}, cfg, 1'b0, 16'h0);
      fr({MODE_NORMAL, SEL_CONFIG}, cfg, 1'b1, {mv[i][2:0], sv[i], dv[i]});
    end
    rd(`OFS_WAKE, 33'h3FF, '1);
    fr({MODE_NORMAL, SEL_LIMP}, 10'h025, 1'b1, {MODE_NORMAL, SEL_CONFIG, cfg});
    fr({MODE_READ_ONLY, SEL_WAKE}, 10'h0, 1'b1,
       {MODE_NORMAL, SEL_LIMP, 10'h3FF});
    rd(`OFS_WAKE, 33'h300, '1);
    rd(`OFS_MODE, 33'h0, 33'h7);
    rd(`OFS_CONFIG, {23'h0, cfg}, '1);
    // Cut frame: no store, no service
    notes.push_back('{33'h0, 33'h0});
    i_spi_host_model.frame({MODE_NORMAL, SEL_CONFIG, ~cfg}, 8);
    rd(`OFS_CONFIG, {23'h0, cfg}, '1);
    apb(1'b1, `OFS_LIMP, 32'h3D);
    apb(1'b1, `OFS_MODE, 32'h1);
    fr({MODE_NORMAL, SEL_CONFIG}, cfg, 1'b0, 16'h0);
    rd(`OFS_LIMP, 33'h25, '1);
    fr({MODE_NORMAL, SEL_LIMP}, 10'h0, 1'b0, 16'h0);
    rd(`OFS_LIMP, 33'h0, 33'h7);
    // Read-only readout of limp word clears reset reason
    apb(1'b1, `OFS_LIMP, 32'h18);
    fr({MODE_READ_ONLY, SEL_LIMP}, 10'h0, 1'b1,
       {MODE_NORMAL, SEL_LIMP, 10'h018});
    rd(`OFS_LIMP, 33'h0, '1);
    chk("limp_off", 33'(limp), 33'h0);
    repeat (20) @(posedge clk);
    chk("wd_count", 33'(wd_n), 33'(nfr));
    chk("notes_left", 33'(notes.size()), 33'h0);
    wrap_up;
  end
  // Watchdog against a hang
  initial begin
    #1000000;
    errors++;
    wrap_up;
  end
endmodule // spi_status_readout_test
bind spi_status_readout spi_status_readout_monitor i_spi_status_readout_monitor (
  .CLK_SYS_I, .SYS_RST_I, .PSEL_I, .PENABLE_I, .PREADY_O, .PSLVERR_O,
  .PRDATA_O, .SPI_CS_N_I, .SPI_SDO_OE_O, .WD_SERVICE_O);
